/* File: design/acp_cfg.svh */
// Constants of the serial command port: command codes, configuration bit positions, counts.
// Assumes it is included by name from the design modules of the port.
// What this block does
// - Sixteen-bit frames, MSB first, command then data
// - Config read: four junk bits, then config
// - Result in bits 15..4, four trailing zeros
// - Straight binary: low ref 000, top FFF
// - Two's complement: low ref 800, top 7FF
// - Frame sync high: rising samples, falling shifts
// - Frame sync used: falling samples, rising shifts
// - Four-bit command; only config write uses data
// - Codes 0..7 select channels; even on four
// - Code 8 enters software power-down
// - Code 9 returns config in low bits
// - Code A writes twelve data bits to config
// - Codes B, C, D select test voltages
// - Code E reads one stored result
// - Successive approximation, one bit per step, MSB first
// - Output released when deselected and after bit sixteen
// - Conversion paced by the serial clock
// - Sampling starts once a conversion command decodes
`ifndef ACP_CFG_SVH
`define ACP_CFG_SVH
`define ACP_FRAME_BITS 5'd16
`define ACP_CMD_LAST_BIT 5'd3
`define ACP_WORD_LAST_BIT 5'd15
`define ACP_CMD_CH_LAST 4'h7
`define ACP_CMD_PDOWN 4'h8
`define ACP_CMD_RDCFG 4'h9
`define ACP_CMD_WRCFG 4'ha
`define ACP_CMD_TEST_MID 4'hb
`define ACP_CMD_TEST_HI 4'hd
`define ACP_CMD_FIFO 4'he
`define ACP_CMD_RSVD 4'hf
`define ACP_CFG_RESET 12'h000
`define ACP_CFG_REFINT 11
`define ACP_CFG_TWOS 10
`define ACP_CFG_LONG 9
`define ACP_CFG_HALF 8
`define ACP_SAMPLE_SHORT 5'd12
`define ACP_SAMPLE_LONG 5'd24
`define ACP_SAR_MSB 12'h800
`define ACP_SYNC_INIT 4'h0
`endif

/* File: design/acp_pkg.sv */
// Types shared by the serial command port modules.
// Assumes nothing of its surroundings.
package acp_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} acp_state_e;
  typedef logic [11:0] acp_code_t;
endpackage : acp_pkg

/* File: design/acp_result_mem.sv */
// Small result store of the serial command port, registered read data.
// Assumes one clock; the caller keeps the pointers.
`timescale 1ns/1ps
`default_nettype none
module acp_result_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 12,
  parameter int AW = 3
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : acp_result_mem
`default_nettype wire

/* File: design/acp_serial_port.sv */
// Serial command port and successive-approximation control of a 12-bit converter.
// Assumes sclk comes from the host, comp_in from the analog comparator, and dac_code drives the trial DAC.
`timescale 1ns/1ps
`default_nettype none
`include "acp_cfg.svh"
module acp_serial_port #(
  parameter int NUM_CH = 8,
  parameter int FIFO_DEPTH = 8,
  parameter int FIFO_AW = 3
) (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial link from the host
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic frame_sync,
  input wire logic sdi,
  output logic sdo_o,
  output logic sdo_oe,
  // Analog front end
  input wire logic comp_in,
  output logic [11:0] dac_code,
  output logic sample_en,
  output logic conv_busy,
  output logic [3:0] mux_sel,
  output logic power_down,
  output logic ref_internal,
  // Configuration and status
  output logic [11:0] config_register,
  output logic [FIFO_AW:0] fifo_level
);

  // ---------------------------------------------------------------
  // Frame capture on the serial clock
  // ---------------------------------------------------------------
  // The frame style is caught when select falls; in frame-sync style the
  // sampling clock is the inverted serial clock, so one set of flops serves both.
  logic fs_style;
  logic [11:0] tx_res;
  logic [11:0] tx_cfg;
  logic [15:0] rx;
  logic [4:0] icnt;
  logic [4:0] ocnt;
  logic [3:0] cmd_hold;
  logic [15:0] word_hold;
  logic cmd_tgl;
  logic done_tgl;
  logic [11:0] rd_data;
  wire sample_clk = sclk ^ fs_style;
  wire fs_restart = fs_style && frame_sync;
  wire [15:0] next_rx = {rx[14:0], sdi};
  wire rx_shift = !cs_n && !fs_restart;
  wire [11:0] res_word = (fifo_level == '0) ? 12'h000 : rd_data;

  always_ff @(negedge cs_n or negedge rst_n) begin
    if (!rst_n) begin
      fs_style <= 1'b0;
      tx_res <= 12'h000;
      tx_cfg <= 12'h000;
    end else begin
      fs_style <= !frame_sync;
      tx_res <= res_word;
      tx_cfg <= config_register;
    end
  end

  always_ff @(posedge sample_clk or posedge cs_n or negedge rst_n) begin
    if (cs_n || !rst_n) begin
      icnt <= 5'd0;
      rx <= 16'h0000;
    end else if (fs_restart) begin
      icnt <= 5'd0;
    end else if (icnt != `ACP_FRAME_BITS) begin
      rx <= next_rx;
      icnt <= icnt + 5'd1;
    end
  end

  // Command and whole word are held here so the system side reads them stable.
  always_ff @(posedge sample_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_hold <= 4'h0;
      word_hold <= 16'h0000;
      cmd_tgl <= 1'b0;
      done_tgl <= 1'b0;
    end else if (rx_shift) begin
      if (icnt == `ACP_CMD_LAST_BIT) begin
        cmd_hold <= next_rx[3:0];
        cmd_tgl <= !cmd_tgl;
      end
      if (icnt == `ACP_WORD_LAST_BIT) begin
        word_hold <= next_rx;
        done_tgl <= !done_tgl;
      end
    end
  end

  // ---------------------------------------------------------------
  // Serial output
  // ---------------------------------------------------------------
  wire rd_cfg = (cmd_hold == `ACP_CMD_RDCFG) && (ocnt >= 5'd4);
  wire [15:0] tx_word = rd_cfg ? {4'h0, tx_cfg} : {tx_res, 4'h0};

  always_ff @(negedge sample_clk or posedge cs_n or negedge rst_n) begin
    if (cs_n || !rst_n) begin
      ocnt <= 5'd0;
    end else if (fs_restart) begin
      ocnt <= 5'd0;
    end else if (icnt != 5'd0 && ocnt != `ACP_FRAME_BITS) begin
      ocnt <= ocnt + 5'd1;
    end
  end

  assign sdo_o = tx_word[~ocnt[3:0]];
  assign sdo_oe = !cs_n && !ocnt[4];

  // ---------------------------------------------------------------
  // Crossing into the system clock
  // ---------------------------------------------------------------
  // Bits: 3 serial clock, 2 comparator, 1 command toggle, 0 word toggle.
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;
  logic [3:0] filt;
  logic [3:0] filt_q;
  wire [3:0] next_filt = (sync2 & sync3) | (filt & (sync2 ^ sync3));
  wire sclk_rise = filt[3] && !filt_q[3];
  wire comp = filt[2];
  wire cmd_ev = filt[1] ^ filt_q[1];
  wire done_ev = filt[0] ^ filt_q[0];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1 <= `ACP_SYNC_INIT;
      sync2 <= `ACP_SYNC_INIT;
      sync3 <= `ACP_SYNC_INIT;
      filt <= `ACP_SYNC_INIT;
      filt_q <= `ACP_SYNC_INIT;
    end else begin
      sync1 <= {sclk, comp_in, cmd_tgl, done_tgl};
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
      filt_q <= filt;
    end
  end

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  wire [3:0] cmd = cmd_hold;
  wire cmd_chan = (cmd <= `ACP_CMD_CH_LAST) && (NUM_CH == 8 || !cmd[0]);
  wire cmd_test = (cmd >= `ACP_CMD_TEST_MID) && (cmd <= `ACP_CMD_TEST_HI);
  wire cmd_conv = cmd_chan || cmd_test;
  wire [3:0] next_mux = (cmd_chan && NUM_CH != 8) ? {2'b00, cmd[2:1]} : cmd;
  wire cfg_wr = done_ev && (word_hold[15:12] == `ACP_CMD_WRCFG);
  wire pd_set = cmd_ev && (cmd == `ACP_CMD_PDOWN);
  wire conv_go = cmd_ev && cmd_conv;
  wire pop = cmd_ev && (cmd_conv || cmd == `ACP_CMD_FIFO) && (fifo_level != '0);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      config_register <= `ACP_CFG_RESET;
      power_down <= 1'b0;
      mux_sel <= 4'h0;
      ref_internal <= 1'b0;
    end else begin
      if (cfg_wr) begin
        config_register <= word_hold[11:0];
      end
      if (pd_set) begin
        power_down <= 1'b1;
      end else if (conv_go) begin
        power_down <= 1'b0;
      end
      if (conv_go) begin
        mux_sel <= next_mux;
      end
      ref_internal <= config_register[`ACP_CFG_REFINT];
    end
  end

  // ---------------------------------------------------------------
  // Sampling and successive approximation
  // ---------------------------------------------------------------
  acp_pkg::acp_state_e state;
  acp_pkg::acp_state_e next_state;
  logic [4:0] scnt;
  logic [11:0] mask;
  logic half;
  wire [4:0] samp_last = (config_register[`ACP_CFG_LONG] ? `ACP_SAMPLE_LONG : `ACP_SAMPLE_SHORT) - 5'd1;
  wire step = sclk_rise && (!config_register[`ACP_CFG_HALF] || half);
  wire [11:0] next_sar = (comp ? dac_code : (dac_code & ~mask)) | (mask >> 1);
  wire push = (state == acp_pkg::ST_CONVERT) && step && mask[0];
  wire [11:0] wr_data = config_register[`ACP_CFG_TWOS] ? {!next_sar[11], next_sar[10:0]} : next_sar;

  always_comb begin
    next_state = state;
    case (state)
      acp_pkg::ST_IDLE: begin
        if (conv_go) begin
          next_state = acp_pkg::ST_SAMPLE;
        end
      end
      acp_pkg::ST_SAMPLE: begin
        if (sclk_rise && scnt == samp_last) begin
          next_state = acp_pkg::ST_CONVERT;
        end
      end
      acp_pkg::ST_CONVERT: begin
        if (push) begin
          next_state = acp_pkg::ST_IDLE;
        end
      end
      default: next_state = acp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= acp_pkg::ST_IDLE;
      scnt <= 5'd0;
      sample_en <= 1'b0;
      conv_busy <= 1'b0;
    end else begin
      state <= next_state;
      sample_en <= (next_state == acp_pkg::ST_SAMPLE);
      conv_busy <= (next_state != acp_pkg::ST_IDLE);
      if (state == acp_pkg::ST_SAMPLE && sclk_rise) begin
        scnt <= scnt + 5'd1;
      end else if (state != acp_pkg::ST_SAMPLE) begin
        scnt <= 5'd0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dac_code <= 12'h000;
      mask <= 12'h000;
      half <= 1'b0;
    end else if (state == acp_pkg::ST_SAMPLE && next_state == acp_pkg::ST_CONVERT) begin
      dac_code <= `ACP_SAR_MSB;
      mask <= `ACP_SAR_MSB;
      half <= 1'b0;
    end else begin
      if (sclk_rise) begin
        half <= !half;
      end
      if (state == acp_pkg::ST_CONVERT && step) begin
        dac_code <= next_sar;
        mask <= mask >> 1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Result store
  // ---------------------------------------------------------------
  // A result that arrives with the store full is dropped.
  logic [FIFO_AW-1:0] wr_ptr;
  logic [FIFO_AW-1:0] rd_ptr;
  wire do_push = push && (fifo_level != FIFO_DEPTH[FIFO_AW:0]);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fifo_level <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_push && !pop) begin
        fifo_level <= fifo_level + 1'b1;
      end else if (pop && !do_push) begin
        fifo_level <= fifo_level - 1'b1;
      end
    end
  end

  acp_result_mem #(
    .DEPTH(FIFO_DEPTH),
    .WIDTH(12),
    .AW(FIFO_AW)
  ) u_mem (
    .clk(sys_clk),
    .wr_en(do_push),
    .wr_addr(wr_ptr),
    .wr_data(wr_data),
    .rd_addr(rd_ptr),
    .rd_data(rd_data)
  );

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  property p_cfg_write;
    cfg_wr |=> config_register == $past(word_hold[11:0]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

  property p_rsvd_keep;
    done_ev && word_hold[15:12] == `ACP_CMD_RSVD |=> $stable(config_register);
  endproperty
  a_rsvd_keep: assert property (p_rsvd_keep) else $error("reserved code changed config");

  property p_pdown;
    pd_set |=> power_down;
  endproperty
  a_pdown: assert property (p_pdown) else $error("power-down not entered");

  property p_sample_start;
    conv_go && state == acp_pkg::ST_IDLE |=> sample_en ##1 sample_en;
  endproperty
  a_sample_start: assert property (p_sample_start) else $error("sampling did not start");

  property p_chan;
    conv_go && cmd_chan && NUM_CH == 8 |=> mux_sel == $past(cmd);
  endproperty
  a_chan: assert property (p_chan) else $error("channel select wrong");

  property p_sar_start;
    state == acp_pkg::ST_SAMPLE && next_state == acp_pkg::ST_CONVERT |=> dac_code == 12'h800 && conv_busy;
  endproperty
  a_sar_start: assert property (p_sar_start) else $error("conversion did not start at MSB");

  property p_scnt_paced;
    state == acp_pkg::ST_SAMPLE && !sclk_rise && next_state == acp_pkg::ST_SAMPLE |=> $stable(scnt);
  endproperty
  a_scnt_paced: assert property (p_scnt_paced) else $error("sampling advanced without serial clock");

  property p_pop;
    pop && !do_push |=> fifo_level == $past(fifo_level) - 1'b1;
  endproperty
  a_pop: assert property (p_pop) else $error("result read did not remove entry");

  property p_oe_end;
    cs_n || ocnt == `ACP_FRAME_BITS |-> !sdo_oe;
  endproperty
  a_oe_end: assert property (p_oe_end) else $error("output still driven after bit sixteen");

  c_cfg_write: cover property (cfg_wr);
  c_conv_done: cover property (do_push);
  c_pop: cover property (pop);
  c_fs_frame: cover property (@(posedge sample_clk) fs_style && icnt == 5'd15);

endmodule : acp_serial_port
`default_nettype wire

/* File: sim/acp_host_model.sv */
// Host serial port model: drives one sixteen-bit frame per call of xfer and collects the reply.
// Assumes the bench feeds back sdo_o and sdo_oe; the serial clock stands still between frames.
`timescale 1ns/1ps
`default_nettype none
module acp_host_model (
  // Serial link
  output logic sclk,
  output logic cs_n,
  output logic frame_sync,
  output logic sdi,
  input wire logic sdo_o,
  input wire logic sdo_oe
);
  // ----------------------------------------
  // Frame driver
  // ----------------------------------------
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    frame_sync = 1'b1;
    sdi = 1'b0;
  end
  // A released output reads as the inverse of the last bit taken.
  task automatic xfer(input logic [15:0] word, input logic dsp, output logic [15:0] rx);
    rx = 16'h0000;
    frame_sync = ~dsp;
    #31.3;
    cs_n = 1'b0;
    // A one-clock sync pulse opens a frame-sync style frame; its fall starts the cycle.
    if (dsp) begin
      #31.25;
      frame_sync = 1'b1;
      #31.25;
      sclk = 1'b1;
      #62.5;
      sclk = 1'b0;
    end
    for (int i = 15; i >= 0; i--) begin
      if (!dsp) sdi = word[i];
      #62.5;
      if (!dsp) rx = {rx[14:0], sdo_oe ? sdo_o : ~rx[0]};
      sclk = 1'b1;
      // In frame-sync style data moves on the rising edge, away from the sampling fall.
      if (dsp) begin
        frame_sync = 1'b0;
        sdi = word[i];
      end
      #62.5;
      if (dsp) rx = {rx[14:0], sdo_oe ? sdo_o : ~rx[0]};
      sclk = 1'b0;
    end
    #62.5;
    sdi = ~sdi;
    #62.5;
    cs_n = 1'b1;
    frame_sync = 1'b1;
    #250;
  endtask : xfer
endmodule : acp_host_model
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench of the serial command port against a queue model of the result store.
// Assumes the port, its package and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK_EQ(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t: %h expected %h", $time, (a), (b)); end end
module tb_top;
  // ----------------------------------------
  // Signals and models
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic rst_n = 1'b1;
  logic comp_in = 1'b0;
  logic [11:0] vin = 12'h000;
  logic [11:0] cfg = 12'h000;
  logic [15:0] rx;
  logic [11:0] q[$];
  int mismatches = 0;
  int checked = 0;
  wire logic sclk, cs_n, frame_sync, sdi, sdo_o, sdo_oe;
  wire logic sample_en, conv_busy, power_down, ref_internal;
  wire logic [11:0] dac_code;
  wire logic [11:0] config_register;
  wire logic [3:0] mux_sel;
  wire logic [3:0] fifo_level;

  always #5 sys_clk = ~sys_clk;
  // The comparator sees the input at or above the trial code.
  always @(negedge sys_clk) comp_in <= (vin >= dac_code);

  acp_serial_port i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
    .frame_sync(frame_sync), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .comp_in(comp_in),
    .dac_code(dac_code), .sample_en(sample_en), .conv_busy(conv_busy), .mux_sel(mux_sel),
    .power_down(power_down), .ref_internal(ref_internal), .config_register(config_register),
    .fifo_level(fifo_level));
  acp_host_model i_host (.sclk(sclk), .cs_n(cs_n), .frame_sync(frame_sync), .sdi(sdi),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stop_test;
    if (mismatches == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic frame(input logic [15:0] w, input logic dsp);
    i_host.xfer(w, dsp, rx);
    @(negedge sys_clk);
    `CHK_EQ(sdo_oe, 1'b0)
  endtask : frame

  // Reads the store head with the given command and retires it from the model.
  task automatic take(input logic [3:0] c, input logic dsp);
    logic [15:0] exp;
    exp = {(q.size() > 0) ? q[0] : 12'h000, 4'h0};
    frame({c, 12'h000}, dsp);
    `CHK_EQ(rx, exp)
    if (q.size() > 0) void'(q.pop_front());
  endtask : take

  // Sampling starts on the clocks left in the command frame; the conversion steps are paced by the clocks of later frames.
  task automatic convert(input logic [3:0] c, input logic dsp);
    int k;
    vin = (c == 4'hb) ? 12'h800 : (c == 4'hc) ? 12'h000 : (c == 4'hd) ? 12'hfff : 12'($urandom);
    take(c, dsp);
    `CHK_EQ(mux_sel, c)
    `CHK_EQ(power_down, 1'b0)
    `CHK_EQ(conv_busy, 1'b1)
    `CHK_EQ(sample_en, cfg[9])
    for (k = 0; k < 8 && conv_busy === 1'b1; k++) begin
      frame(16'h9000, dsp);
      `CHK_EQ(rx[11:0], cfg)
    end
    if (k == 8) begin
      mismatches++;
      stop_test();
    end
    `CHK_EQ(dac_code, vin)
    q.push_back(cfg[10] ? vin ^ 12'h800 : vin);
    `CHK_EQ(fifo_level, 4'(q.size()))
  endtask : convert

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h94e03fa8));
    // Reset falls after time zero so that the link flops with asynchronous reset see an edge.
    #1;
    rst_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    `CHK_EQ(config_register, 12'h000)
    frame(16'ha000, 1'b0);
    `CHK_EQ(config_register, 12'h000)
    for (int p = 0; p < 2; p++) begin
      cfg = {1'($urandom), p[0], 2'($urandom), 8'h00};
      frame({4'ha, cfg}, p[0]);
      `CHK_EQ(config_register, cfg)
      `CHK_EQ(ref_internal, cfg[11])
      for (int c = 0; c < 14; c++) begin
        if (c < 8 || c > 10) convert(4'(c), p[0]);
      end
      frame(16'h8000, p[0]);
      `CHK_EQ(power_down, 1'b1)
      frame({4'hf, ~cfg}, p[0]);
      `CHK_EQ(config_register, cfg)
      `CHK_EQ(fifo_level, 4'(q.size()))
      take(4'he, p[0]);
      take(4'he, p[0]);
      `CHK_EQ(fifo_level, 4'h0)
    end
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
